/* File: watchdog_interval_timer.sv */
// Watchdog / interval timer with Wishbone classic slave and settle-time select.
// Assumes one clock clk_i (main clock), synchronous reset, pins synchronised here.
//
// Contract
// RQ1 - Writing one to run bit clears counter and starts counting; zero has no effect.
// RQ2 - Software cannot clear run bit once set; only reset stops counting.
// RQ3 - Mode bits are sticky once set; watchdog mode locks out interval mode.
// RQ4 - Mode hi zero gives interval interrupt; hi one, action zero gives NMI.
// RQ5 - Both mode bits set makes overflow raise system reset instead.
// RQ6 - Interval mode with run set acts as periodic timer interrupting each overflow.
// RQ7 - Prescaler is not cleared on restart; first overflow may come slightly early.
// RQ8 - Three-bit period field selects 2^12..2^18 and 2^20 main-clock cycles.
// RQ9 - Software must restart run bit within each detection period.
// RQ10 - Counter keeps counting in halt and freezes in stop.
// RQ11 - Software should set run bit just before executing stop.
// RQ12 - Counter stops while processor runs from subsystem clock.
// RQ13 - Interval interrupt obeys mask and priority flags; highest default priority.
// RQ14 - Reset loads mode register with zero: stopped, interval mode.
// RQ15 - Settle field codes 0..4 give 2^12,2^14,2^15,2^16,2^17 cycles.
// RQ16 - Settle register resets to code four.
// RQ17 - Period field codes 0..7 map to 2^12..2^18,2^20; resets to zero.
// RQ18 - Each overflow is a one-cycle pulse and counting restarts from zero.
`timescale 1ns/1ns
`include "wdt_consts.svh"

module watchdog_interval_timer #(
  parameter int PRESCALE_LOG2 = `PRESCALE_LOG2
) (
  input wire logic clk_i,                // Main clock, 125 MHz
  input wire logic rst_i,                // Synchronous reset, active high
  input wire logic [31:0] wb_adr_i,      // Wishbone byte address
  input wire logic [31:0] wb_dat_i,      // Wishbone write data
  input wire logic [3:0] wb_sel_i,       // Wishbone byte select
  input wire logic wb_we_i,              // Wishbone write enable
  input wire logic wb_cyc_i,             // Wishbone cycle
  input wire logic wb_stb_i,             // Wishbone strobe
  output logic [31:0] wb_dat_o,          // Wishbone read data
  output logic wb_ack_o,                 // Wishbone acknowledge
  input wire logic cpu_halt_i,           // Processor in halt (pin)
  input wire logic cpu_stop_i,           // Processor in stop (pin)
  input wire logic cpu_on_subclk_i,      // Processor on subsystem clock (pin)
  output wdt_pkg::dog_mode_t mode_o,     // Decoded operating mode
  output logic interval_irq_o,           // Maskable interval request, one pulse
  output logic interval_irq_priority_o,  // Priority flag of interval request
  output logic nmi_o,                    // Non-maskable request, one pulse
  output logic sys_reset_o,              // System reset request, one pulse
  output logic [`COUNT_W-1:0] settle_cycles_o, // Selected settle time in cycles
  output logic irq_o                     // Level interrupt, status masked by irq_mask
);
  import wdt_pkg::*;

  // --------------------------------------------------------------------------
  // Period, settle and address decode functions
  // --------------------------------------------------------------------------
  function automatic logic [4:0] period_log2(input logic [2:0] code);
    case (code)
      3'h0: period_log2 = 5'h0C; // [RQ8] [RQ17]
      3'h1: period_log2 = 5'h0D;
      3'h2: period_log2 = 5'h0E;
      3'h3: period_log2 = 5'h0F;
      3'h4: period_log2 = 5'h10;
      3'h5: period_log2 = 5'h11;
      3'h6: period_log2 = 5'h12;
      default: period_log2 = 5'h14;
    endcase
  endfunction

  function automatic logic [4:0] settle_log2(input logic [2:0] code);
    case (code)
      3'h0: settle_log2 = 5'h0C; // [RQ15]
      3'h1: settle_log2 = 5'h0E;
      3'h2: settle_log2 = 5'h0F;
      3'h3: settle_log2 = 5'h10;
      default: settle_log2 = 5'h11;
    endcase
  endfunction

  function automatic logic hit(input logic [31:0] adr, input logic [15:0] idx);
    hit = (adr[17:0] == `ADDR_OF(idx));
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end
    else
    begin
      pin_meta <= {cpu_on_subclk_i, cpu_stop_i, cpu_halt_i};
      pin_sync <= pin_meta;
    end
  end
  logic in_stop;
  logic on_subclk;
  assign in_stop = pin_sync[1];
  assign on_subclk = pin_sync[2];

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic req;
  logic wr;
  logic rd;
  logic wr_mode;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign wr_mode = wr & hit(wb_adr_i, `IDX_DOG_MODE);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  logic run;
  logic mode_hi;
  logic action;
  logic [2:0] period_sel;
  logic [2:0] settle_sel;
  logic [2:0] irq_mask;
  logic [1:0] irq_ctrl;
  logic restart;
  assign restart = wr_mode & wb_dat_i[`RUN_BIT];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      run <= 1'(`DOG_MODE_RST >> `RUN_BIT); // [RQ14]
    else if (wr_mode)
      run <= run | wb_dat_i[`RUN_BIT]; // [RQ2]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_hi <= 1'(`DOG_MODE_RST >> `MODE_HI_BIT);
    else if (wr_mode)
      mode_hi <= mode_hi | wb_dat_i[`MODE_HI_BIT]; // [RQ3]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      action <= 1'(`DOG_MODE_RST >> `ACTION_BIT);
    else if (wr_mode)
      action <= action | wb_dat_i[`ACTION_BIT]; // [RQ3]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      period_sel <= `PERIOD_SEL_RST; // [RQ17]
    else if (wr & hit(wb_adr_i, `IDX_PERIOD_SEL))
      period_sel <= wb_dat_i[2:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      settle_sel <= `OSC_SETTLE_RST; // [RQ16]
    else if (wr & hit(wb_adr_i, `IDX_OSC_SETTLE))
      settle_sel <= wb_dat_i[2:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask <= `IRQ_MASK_RST;
    else if (wr & hit(wb_adr_i, `IDX_IRQ_MASK))
      irq_mask <= wb_dat_i[2:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_ctrl <= `IRQ_CTRL_RST;
    else if (wr & hit(wb_adr_i, `IDX_IRQ_CTRL))
      irq_ctrl <= wb_dat_i[1:0];
  end

  dog_mode_t mode;
  always_comb
  begin
    case ({mode_hi, action})
      2'b10: mode = MODE_NMI; // [RQ4]
      2'b11: mode = MODE_RESET; // [RQ5]
      default: mode = MODE_INTERVAL; // [RQ4]
    endcase
  end

  // --------------------------------------------------------------------------
  // Prescaler and counter
  // --------------------------------------------------------------------------
  // The prescaler advances whenever the counter is active and is never cleared by a restart, so the first
  // period after a restart is short by up to one prescaler step.
  logic [PRESCALE_LOG2-1:0] prescale;
  logic [`COUNT_W-1:0] count;
  logic tick;
  logic active;
  logic overflow;
  logic [`COUNT_W-1:0] limit;
  assign active = run & ~in_stop & ~on_subclk; // [RQ10] [RQ12]
  assign tick = active & (&prescale);
  assign limit = `COUNT_W'((32'h1 << (32'(period_log2(period_sel)) - PRESCALE_LOG2)) - 32'h1);
  assign overflow = tick & (count >= limit);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prescale <= '0;
    else if (active)
      prescale <= prescale + 1'b1; // [RQ7]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count <= '0;
    else if (restart)
      count <= '0; // [RQ1]
    else if (overflow)
      count <= '0; // [RQ18] [RQ6]
    else if (tick)
      count <= count + 1'b1;
  end

  // --------------------------------------------------------------------------
  // Event outputs
  // --------------------------------------------------------------------------
  logic [2:0] event_now;
  assign event_now = {overflow & (mode == MODE_RESET),
                      overflow & (mode == MODE_NMI),
                      overflow & (mode == MODE_INTERVAL)};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      interval_irq_o <= 1'b0;
    else
      interval_irq_o <= event_now[`ST_INTERVAL] & ~irq_ctrl[`CTRL_MASK_BIT]; // [RQ13] [RQ6]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      nmi_o <= 1'b0;
    else
      nmi_o <= event_now[`ST_NMI]; // [RQ4]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sys_reset_o <= 1'b0;
    else
      sys_reset_o <= event_now[`ST_RESET]; // [RQ5]
  end

  // --------------------------------------------------------------------------
  // Sticky status, cleared by reading it; a new event wins over the clear
  // --------------------------------------------------------------------------
  logic [2:0] status;
  logic rd_status;
  assign rd_status = rd & hit(wb_adr_i, `IDX_IRQ_STATUS);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status <= 3'h0;
    else if (rd_status)
      status <= event_now;
    else
      status <= status | event_now;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |((rd_status ? event_now : (status | event_now)) & irq_mask);
  end

  // --------------------------------------------------------------------------
  // Read data and static outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0;
    else if (rd)
    begin
      if (hit(wb_adr_i, `IDX_DOG_MODE))
        wb_dat_o <= {24'h0, run, 2'b00, mode_hi, action, 3'b000};
      else if (hit(wb_adr_i, `IDX_PERIOD_SEL))
        wb_dat_o <= {29'h0, period_sel};
      else if (hit(wb_adr_i, `IDX_OSC_SETTLE))
        wb_dat_o <= {29'h0, settle_sel};
      else if (rd_status)
        wb_dat_o <= {29'h0, status};
      else if (hit(wb_adr_i, `IDX_IRQ_MASK))
        wb_dat_o <= {29'h0, irq_mask};
      else if (hit(wb_adr_i, `IDX_IRQ_CTRL))
        wb_dat_o <= {30'h0, irq_ctrl};
      else
        wb_dat_o <= 32'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_o <= MODE_INTERVAL;
    else
      mode_o <= mode;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      interval_irq_priority_o <= 1'(`IRQ_CTRL_RST >> `CTRL_PRIO_BIT);
    else
      interval_irq_priority_o <= irq_ctrl[`CTRL_PRIO_BIT]; // [RQ13]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      settle_cycles_o <= '0;
    else
      settle_cycles_o <= `COUNT_W'(32'h1 << settle_log2(settle_sel)); // [RQ15]
  end
endmodule

/* File: wdt_consts.svh */
// Constants for the watchdog / interval timer block.
// Assumes inclusion by bare name from the design module and the checker.
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register word indices, byte address is index times four (printed offsets are not all multiples of four)
// ----------------------------------------------------------------------------
`define IDX_DOG_MODE      16'hFFF9
`define IDX_OSC_SETTLE    16'hFFFA
`define IDX_PERIOD_SEL    16'hFF42
`define IDX_IRQ_STATUS    16'h0000
`define IDX_IRQ_MASK      16'h0001
`define IDX_IRQ_CTRL      16'h0002
`define ADDR_OF(idx)      ({(idx), 2'b00})

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define RUN_BIT           7
`define MODE_HI_BIT       4
`define ACTION_BIT        3
`define DOG_MODE_RST      8'h00
`define OSC_SETTLE_RST    3'h4
`define PERIOD_SEL_RST    3'h0
`define IRQ_MASK_RST      3'h0
`define IRQ_CTRL_RST      2'h3
`define ST_INTERVAL       0
`define ST_NMI            1
`define ST_RESET          2
`define CTRL_MASK_BIT     0
`define CTRL_PRIO_BIT     1

// ----------------------------------------------------------------------------
// Divider: one prescaler step per 2^PRESCALE_LOG2 main-clock cycles
// ----------------------------------------------------------------------------
`define PRESCALE_LOG2     4
`define COUNT_W           20

`endif

/* File: wdt_pkg.sv */
// Types shared by the watchdog / interval timer block.
// Assumes wdt_consts.svh is on the include path.
package wdt_pkg;
  typedef enum logic [1:0] {
    MODE_INTERVAL,
    MODE_NMI,
    MODE_RESET
  } dog_mode_t;
endpackage

/* File: watchdog_interval_timer_assertions.sv */
// Port-level checker for the watchdog / interval timer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`include "wdt_consts.svh"
module watchdog_interval_timer_assertions (
  input wire logic clk_i, // Main clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_ack_o, // Bus acknowledge
  input wire logic cpu_stop_i, // Stop level
  input wire logic cpu_on_subclk_i, // Subclock level
  input wdt_pkg::dog_mode_t mode_o, // Mode
  input wire logic interval_irq_o, // Interval pulse
  input wire logic interval_irq_priority_o, // Priority flag
  input wire logic nmi_o, // Non-maskable pulse
  input wire logic sys_reset_o, // Reset pulse
  input wire logic [`COUNT_W-1:0] settle_cycles_o // Settle time
);
  import wdt_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence take_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ev_s; interval_irq_o || nmi_o || sys_reset_o; endsequence
  a_ack_next: assert property (take_s |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_event_pulse: assert property (ev_s |=> not ev_s)
    else $error("event pulse longer than one cycle");
  a_one_kind: assert property ($onehot0({interval_irq_o, nmi_o, sys_reset_o}))
    else $error("two event kinds at once");
  a_reset_mode: assert property (sys_reset_o |-> mode_o == MODE_RESET)
    else $error("reset pulse outside reset mode");
  a_nmi_mode: assert property (nmi_o |-> mode_o == MODE_NMI)
    else $error("nmi pulse outside nmi mode");
  a_mode_sticky: assert property (mode_o != MODE_INTERVAL |=> mode_o != MODE_INTERVAL)
    else $error("watchdog mode left without reset");
  a_settle_reset: assert property ($fell(rst_i) |=> settle_cycles_o == 20'h20000)
    else $error("settle time after reset wrong");
  a_settle_legal: assert property (!$past(rst_i) |-> $onehot(settle_cycles_o) &&
    settle_cycles_o != 20'h02000 && settle_cycles_o <= 20'h20000)
    else $error("settle time outside the code table");
  a_prio_reset: assert property ($fell(rst_i) |-> interval_irq_priority_o)
    else $error("priority flag not set after reset");
  a_freeze: assert property ((cpu_stop_i || cpu_on_subclk_i) [*8] |=> not ev_s)
    else $error("overflow while frozen");
endmodule
bind watchdog_interval_timer watchdog_interval_timer_assertions chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cpu_stop_i(cpu_stop_i),
  .cpu_on_subclk_i(cpu_on_subclk_i), .mode_o(mode_o), .interval_irq_o(interval_irq_o),
  .interval_irq_priority_o(interval_irq_priority_o), .nmi_o(nmi_o), .sys_reset_o(sys_reset_o),
  .settle_cycles_o(settle_cycles_o));

/* File: watchdog_interval_timer_tb.sv */
// Self-checking bench for the watchdog / interval timer.
// Assumes the design, its package and its checker are compiled first.
`timescale 1ns/1ns
module watchdog_interval_timer_tb;
  import wdt_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, halt = 0, stop = 0, subclk = 0;
  logic [31:0] adr = 0, dat = 0, q, dat_o, seed = 32'hFEDF;
  logic ack, iirq, prio, nmi, srst, irq;
  logic [19:0] settle;
  dog_mode_t mode;
  int miscompares = 0, total_checks = 0, n, c, ticks = 0;
  always #4 clk_i = ~clk_i;
  watchdog_interval_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h1),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .cpu_halt_i(halt),
    .cpu_stop_i(stop), .cpu_on_subclk_i(subclk), .mode_o(mode), .interval_irq_o(iirq),
    .interval_irq_priority_o(prio), .nmi_o(nmi), .sys_reset_o(srst), .settle_cycles_o(settle), .irq_o(irq));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] settle_exp(input int k);
    return k == 0 ? 32'h1000 : 32'h1 << (k + 13);
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    dat <= {seed[31:8], d[7:0]};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    chk(32'(k), 32'h2);
  endtask
  task rc(input logic [31:0] a, input logic [7:0] e);
    wb(0, a, 0);
    chk(32'(q[7:0]), 32'(e));
  endtask
  // Cycles until the chosen event pulse (0 interval, 1 nmi, 2 reset)
  task pw(input int b);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while ((b == 0 ? iirq : (b == 1 ? nmi : srst)) !== 1'b1 && n < 40000);
  endtask
  // Count event pulses seen over k cycles
  task frz(input int k);
    n = 0;
    repeat (k)
    begin
      @(negedge clk_i);
      n += int'(iirq | nmi | srst);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    ticks++;
    if (ticks == 100000)
    begin
      miscompares++;
      results;
    end
  end
  // ----
  // Sequence
  // ----
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    repeat (2) @(negedge clk_i);
    chk(32'(settle), settle_exp(4));
    chk(32'(prio), 32'h1);
    rc(32'h3FFE4, 8'h00);
    rc(32'h3FD08, 8'h00);
    rc(32'h3FFE8, 8'h04);
    wb(1, 32'h100, 8'hFF);
    rc(32'h100, 8'h00);
    for (c = 0; c < 5; c++)
    begin
      seed = xs(seed);
      wb(1, 32'h3FFE8, 32'(c));
      @(negedge clk_i);
      chk(32'(settle), settle_exp(c));
      rc(32'h3FFE8, 8'(c));
    end
    $display("register test done");
    wb(1, 32'h8, 8'h02);
    wb(1, 32'h4, 8'h01);
    halt <= 1;
    wb(1, 32'h3FFE4, 8'h80);
    pw(0);
    chk(32'(n >= 4076 && n <= 4100), 32'h1);
    pw(0);
    chk(32'(n), 32'h1000);
    repeat (2) @(negedge clk_i);
    chk(32'(irq), 32'h1);
    rc(32'h0, 8'h01);
    @(negedge clk_i);
    chk(32'(irq), 32'h0);
    seed = xs(seed);
    c = 1 + int'(seed[0]);
    wb(1, 32'h3FD08, 32'(c));
    wb(1, 32'h3FFE4, 8'h80);
    pw(0);
    pw(0);
    chk(32'(n), 32'h1000 << c);
    wb(1, 32'h3FD08, 8'h00);
    wb(1, 32'h3FFE4, 8'h00);
    rc(32'h3FFE4, 8'h80);
    pw(0);
    wb(1, 32'h3FFE4, 8'h80);
    stop <= 1;
    frz(5000);
    chk(32'(n), 32'h0);
    @(posedge clk_i);
    {stop, subclk} <= 2'b01;
    frz(5000);
    chk(32'(n), 32'h0);
    @(posedge clk_i);
    subclk <= 0;
    wb(1, 32'h8, 8'h01);
    wb(1, 32'h4, 8'h00);
    wb(0, 32'h0, 0);
    frz(5000);
    chk(32'(n), 32'h0);
    chk(32'(prio), 32'h0);
    chk(32'(irq), 32'h0);
    rc(32'h0, 8'h01);
    $display("interval test done");
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(1, 32'h3FFE4, 8'h90);
    repeat (2) @(negedge clk_i);
    chk(32'(mode), 32'(MODE_NMI));
    repeat (3)
    begin
      frz(3000);
      chk(32'(n), 32'h0);
      wb(1, 32'h3FFE4, 8'h90);
    end
    wb(1, 32'h3FFE4, 8'h80);
    pw(1);
    chk(32'(n >= 4076 && n <= 4100), 32'h1);
    chk(32'(mode), 32'(MODE_NMI));
    wb(1, 32'h3FFE4, 8'h98);
    wb(1, 32'h3FFE4, 8'h00);
    pw(2);
    chk(32'(n <= 4100), 32'h1);
    chk(32'(mode), 32'(MODE_RESET));
    rc(32'h0, 8'h06);
    $display("watchdog test done");
    results;
  end
endmodule
